/* File: pkg/cc_pkg.sv */
/*
 * Shared constants, mode codes and helpers of the capture/compare array.
 * Assumes one clock domain; all users import the whole package.
 */
package cc_pkg;

    // ========================================================
    // Sizes and reset values
    localparam int          NUM_CH         = 16;
    localparam int          CNT_W          = 16;
    localparam int          IDX_W          = 4;
    localparam int          PRESC_W        = 8;
    localparam int          STAGGER_CYCLES = 8;
    localparam int          STAGGER_SHIFT  = $clog2(STAGGER_CYCLES);
    localparam logic [15:0] CNT_RST        = 16'h0000;
    localparam logic [15:0] VAL_RST        = 16'h0000;

    // ========================================================
    // Count clock selection: codes below SEL_SIX are prescaler shifts
    localparam logic [2:0]  SEL_SIX        = 3'h6;
    localparam logic [2:0]  SEL_EXT        = 3'h7;

    // ========================================================
    // Channel modes, Gray codes along the compare path
    typedef enum logic [2:0] {
        MD_OFF     = 3'h0,
        MD_CAPTURE = 3'h1,
        MD_CMP0    = 3'h4,
        MD_CMP1    = 3'h5,
        MD_CMP2    = 3'h7,
        MD_CMP3    = 3'h6
    } mode_t;

    // True for every compare mode
    function automatic logic is_cmp(input mode_t m);
        return m[2];
    endfunction : is_cmp

    // Prescaled tick: prescaler low bits all zero
    function automatic logic presc_tick(input logic [2:0] sel,
                                        input logic stag,
                                        input logic [PRESC_W-1:0] presc);
        logic [3:0]         shift;
        logic [PRESC_W:0]   one;
        logic [PRESC_W-1:0] mask;
        shift = {1'b0, sel} + (stag ? 4'(STAGGER_SHIFT) : 4'h0);
        one   = (PRESC_W+1)'(1) << shift;
        mask  = PRESC_W'(one - (PRESC_W+1)'(1));
        return (presc & mask) == '0;
    endfunction : presc_tick

endpackage : cc_pkg

/* File: pkg/ccr_if.sv */
/*
 * Carrier between the channel control logic and the channel register store.
 * Assumes both ends share ref_clk; the store owns all stored values.
 */
interface ccr_if #(parameter int N = 16, parameter int W = 16);
    logic                 wr_en;
    logic [$clog2(N)-1:0] wr_idx;
    logic [W-1:0]         wr_data;
    logic [N-1:0]         cap_mask;
    logic [N-1:0][W-1:0]  cap_data;
    logic [N-1:0][W-1:0]  value;
    logic [$clog2(N)-1:0] rd_idx;
    logic [W-1:0]         rd_data;

    modport ctrl  (output wr_en, wr_idx, wr_data, cap_mask, cap_data, rd_idx,
                   input  value, rd_data);
    modport store (input  wr_en, wr_idx, wr_data, cap_mask, cap_data, rd_idx,
                   output value, rd_data);
endinterface : ccr_if

/* File: design/ccr_store.sv */
/*
 * Channel register store: sixteen words, capture load, software write,
 * registered read port. Assumes synchronous inputs on ref_clk.
 */
module ccr_store
    import cc_pkg::*;
(
    // Clock and reset
    input  wire logic ref_clk,
    input  wire logic rstn,
    input  wire logic clk_en,
    // Control side
    ccr_if.store      bus
);

    // ========================================================
    // Storage: a capture wins over a software write to the same word
    always_ff @(posedge ref_clk or negedge rstn) begin
        if (!rstn) begin
            bus.value <= '{default: VAL_RST};
        end else if (clk_en) begin
            for (int i = 0; i < NUM_CH; i++) begin
                if (bus.cap_mask[i]) begin
                    bus.value[i] <= bus.cap_data[i];
                end else if (bus.wr_en && bus.wr_idx == IDX_W'(i)) begin
                    bus.value[i] <= bus.wr_data;
                end
            end
        end
    end

    // ========================================================
    // Read port
    always_ff @(posedge ref_clk or negedge rstn) begin
        if (!rstn) begin
            bus.rd_data <= VAL_RST;
        end else if (clk_en) begin
            bus.rd_data <= bus.value[bus.rd_idx];
        end
    end

endmodule : ccr_store

/* File: design/capture_compare_array.sv */
/*
 * Sixteen-channel capture/compare array with two reloadable time bases.
 * Assumes all inputs synchronous to ref_clk; configuration on plain ports.
 */
// Operation
// - Sixteen channels, one system clock resolution in normal operation.
// - Staggered operation gives eight-cycle resolution.
// - Two independent 16-bit timers with reload values are time bases.
// - Count clock: prescaled system clock or external timer six overflow.
// - A time base may count pulses on an external count input.
// - Each channel picks its time base and capture or compare.
// - Each channel owns one pin: capture input or compare output.
// - Capture copies the assigned time base count into the channel.
// - Each capture raises that channel's interrupt request.
// - Capture edge per channel: rising, falling, or both.
// - Compare channels match continuously against their time base.
// - Mode zero: interrupt only, every match in a period.
// - Mode one: every match toggles the pin.
// - Mode two: interrupt only, one per timer period.
// - Mode three: match sets pin, overflow clears it, once per period.
// - Double register: two channels toggle one shared pin.
// - Single event option allows only one edge or pulse.
module capture_compare_array
    import cc_pkg::*;
#(
    parameter int N = NUM_CH,
    parameter int W = CNT_W
)(
    // Clock, reset, enable
    input  wire logic                 ref_clk,
    input  wire logic                 rstn,
    input  wire logic                 clk_en,
    // Time base control
    input  wire logic [1:0]           tb_run,
    input  wire logic [1:0][2:0]      tb_clk_sel,
    input  wire logic [1:0][W-1:0]    reload_val,
    input  wire logic                 stagger_en,
    input  wire logic                 ext_six_ovf,
    input  wire logic                 ext_count_in,
    output logic      [1:0][W-1:0]    tb_count,
    output logic      [1:0]           tb_ovf,
    // Channel configuration
    input  wire mode_t [N-1:0]        ch_mode,
    input  wire logic [N-1:0]         ch_tb_sel,
    input  wire logic [N-1:0][1:0]    ch_edge,
    input  wire logic [N-1:0]         single_ev,
    input  wire logic [N/2-1:0]       dbl_en,
    // Channel register access
    input  wire logic                 wr_en,
    input  wire logic [IDX_W-1:0]     wr_idx,
    input  wire logic [W-1:0]         wr_data,
    input  wire logic [IDX_W-1:0]     rd_idx,
    output logic      [W-1:0]         rd_data,
    // Request flags
    input  wire logic [N-1:0]         req_clr,
    output logic      [N-1:0]         req_flag,
    // Pins
    input  wire logic [N-1:0]         pin_in,
    output logic      [N-1:0]         pin_out,
    output logic      [N-1:0]         pin_oe
);

    localparam int HALF = N / 2;
    localparam logic [W-1:0] CNT_MAX = '1;

    ccr_if #(.N(N), .W(W)) bus ();

    logic [PRESC_W-1:0]   presc_ff;
    logic                 ext_prev_ff;
    logic [1:0][W-1:0]    count_ff;
    logic [1:0]           step_ff, ovf_ff, tick;
    logic [N-1:0]         pin_prev_ff, req_ff, fired_ff, done_ff, pin_lvl_ff;
    logic [N-1:0]         cap_ev, cmp_ev, routed, tog, set3, clr3, drv;

    // ========================================================
    // Register store
    ccr_store u_store (
        .ref_clk (ref_clk),
        .rstn    (rstn),
        .clk_en  (clk_en),
        .bus     (bus)
    );

    assign bus.wr_en   = wr_en;
    assign bus.wr_idx  = wr_idx;
    assign bus.wr_data = wr_data;
    assign bus.rd_idx  = rd_idx;
    assign rd_data     = bus.rd_data;

    // ========================================================
    // Prescaler and external count edge
    always_ff @(posedge ref_clk or negedge rstn) begin
        if (!rstn) begin
            presc_ff    <= '0;
            ext_prev_ff <= 1'b0;
        end else if (clk_en) begin
            presc_ff    <= presc_ff + PRESC_W'(1);
            ext_prev_ff <= ext_count_in;
        end
    end

    // Count clock choice per time base
    always_comb begin
        for (int t = 0; t < 2; t++) begin
            unique case (tb_clk_sel[t])
                SEL_SIX: tick[t] = ext_six_ovf;
                SEL_EXT: tick[t] = ext_count_in & ~ext_prev_ff;
                default: tick[t] = presc_tick(tb_clk_sel[t], stagger_en,
                                              presc_ff);
            endcase
            tick[t] = tick[t] & tb_run[t];
        end
    end

    // ========================================================
    // Time bases: count up, reload on overflow
    always_ff @(posedge ref_clk or negedge rstn) begin
        if (!rstn) begin
            count_ff <= '{default: CNT_RST};
            step_ff  <= '0;
            ovf_ff   <= '0;
        end else if (clk_en) begin
            for (int t = 0; t < 2; t++) begin
                step_ff[t] <= tick[t];
                ovf_ff[t]  <= tick[t] && count_ff[t] == CNT_MAX;
                if (tick[t]) begin
                    if (count_ff[t] == CNT_MAX) begin
                        count_ff[t] <= reload_val[t];
                    end else begin
                        count_ff[t] <= count_ff[t] + W'(1);
                    end
                end
            end
        end
    end

    assign tb_count = count_ff;
    assign tb_ovf   = ovf_ff;

    // ========================================================
    // Channel events
    always_comb begin
        for (int i = 0; i < N; i++) begin
            // Capture on the selected edges
            cap_ev[i] = ch_mode[i] == MD_CAPTURE &&
                        ((ch_edge[i][0] & pin_in[i] & ~pin_prev_ff[i]) |
                         (ch_edge[i][1] & ~pin_in[i] & pin_prev_ff[i]));
            bus.cap_data[i] = count_ff[ch_tb_sel[i]];
            // Compare on each new count of the assigned base
            cmp_ev[i] = is_cmp(ch_mode[i]) && step_ff[ch_tb_sel[i]] &&
                        count_ff[ch_tb_sel[i]] == bus.value[i] &&
                        !done_ff[i] &&
                        !(fired_ff[i] && (ch_mode[i] == MD_CMP2 ||
                                          ch_mode[i] == MD_CMP3));
        end
    end

    assign bus.cap_mask = cap_ev;

    // ========================================================
    // Pin actions, with double register routing to the lower pin
    always_comb begin
        routed = '0;
        for (int j = 0; j < HALF; j++) begin
            routed[j+HALF] = dbl_en[j];
        end
        for (int j = 0; j < N; j++) begin
            tog[j]  = cmp_ev[j] && ch_mode[j] == MD_CMP1 &&
                      !routed[j];
            set3[j] = cmp_ev[j] && ch_mode[j] == MD_CMP3;
            clr3[j] = ch_mode[j] == MD_CMP3 && ovf_ff[ch_tb_sel[j]];
            drv[j]  = (ch_mode[j] == MD_CMP1 || ch_mode[j] == MD_CMP3) &&
                      !routed[j];
        end
        for (int j = 0; j < HALF; j++) begin
            if (dbl_en[j] && ch_mode[j+HALF] == MD_CMP1) begin
                tog[j] = tog[j] | cmp_ev[j+HALF];
                drv[j] = 1'b1;
            end
        end
    end

    // Pin level: a match set outranks toggle and overflow clear
    always_ff @(posedge ref_clk or negedge rstn) begin
        if (!rstn) begin
            pin_lvl_ff <= '0;
        end else if (clk_en) begin
            for (int j = 0; j < N; j++) begin
                if (set3[j]) begin
                    pin_lvl_ff[j] <= 1'b1;
                end else if (tog[j]) begin
                    pin_lvl_ff[j] <= ~pin_lvl_ff[j];
                end else if (clr3[j]) begin
                    pin_lvl_ff[j] <= 1'b0;
                end
            end
        end
    end

    assign pin_out = pin_lvl_ff;
    assign pin_oe  = drv;

    // ========================================================
    // Once-per-period and single event memories
    always_ff @(posedge ref_clk or negedge rstn) begin
        if (!rstn) begin
            fired_ff <= '0;
            done_ff  <= '0;
        end else if (clk_en) begin
            for (int i = 0; i < N; i++) begin
                if (cmp_ev[i]) begin
                    fired_ff[i] <= 1'b1;
                end else if (ovf_ff[ch_tb_sel[i]]) begin
                    fired_ff[i] <= 1'b0;
                end
                done_ff[i] <= single_ev[i] &&
                              (done_ff[i] || cmp_ev[i]);
            end
        end
    end

    // ========================================================
    // Pin history and request flags; a new event beats a clear
    always_ff @(posedge ref_clk or negedge rstn) begin
        if (!rstn) begin
            pin_prev_ff <= '0;
            req_ff      <= '0;
        end else if (clk_en) begin
            pin_prev_ff <= pin_in;
            req_ff      <= (req_ff & ~req_clr) | cap_ev | cmp_ev;
        end
    end

    assign req_flag = req_ff;

    // ========================================================
    // Checks
    sequence s_wrap0;
        clk_en && tick[0] && count_ff[0] == CNT_MAX;
    endsequence

    sequence s_mode0_hit;
        clk_en && cmp_ev[0] && ch_mode[0] == MD_CMP0;
    endsequence

    sequence s_mode3_set;
        clk_en && set3[4];
    endsequence

    sequence s_mode3_clr;
        clk_en && clr3[4] && !set3[4] && !tog[4];
    endsequence

    // Mode two events of channel 1 since its time base last wrapped
    logic [1:0] per_cnt_ff;
    always_ff @(posedge ref_clk or negedge rstn) begin
        if (!rstn) begin
            per_cnt_ff <= '0;
        end else if (clk_en) begin
            if (ch_mode[1] != MD_CMP2) begin
                per_cnt_ff <= '0;
            end else if (ovf_ff[ch_tb_sel[1]]) begin
                per_cnt_ff <= {1'b0, cmp_ev[1]};
            end else if (cmp_ev[1] && per_cnt_ff != 2'h3) begin
                per_cnt_ff <= per_cnt_ff + 2'h1;
            end
        end
    end

    a_cap_flag: assert property (@(posedge ref_clk) disable iff (!rstn)
        clk_en && |cap_ev |=> (req_ff & $past(cap_ev)) == $past(cap_ev))
        else $error("capture did not raise its request");

    a_cap_value: assert property (@(posedge ref_clk) disable iff (!rstn)
        clk_en && cap_ev[3] |=> bus.value[3] == $past(bus.cap_data[3]))
        else $error("captured value differs from time base");

    a_tb_reload: assert property (@(posedge ref_clk) disable iff (!rstn)
        s_wrap0 |=> count_ff[0] == $past(reload_val[0]) && ovf_ff[0])
        else $error("time base did not reload on overflow");

    a_tb_step: assert property (@(posedge ref_clk) disable iff (!rstn)
        clk_en && tick[0] && count_ff[0] != CNT_MAX
        |=> count_ff[0] == $past(count_ff[0]) + W'(1))
        else $error("time base did not advance by one");

    a_mode0_req: assert property (@(posedge ref_clk) disable iff (!rstn)
        s_mode0_hit |=> req_ff[0] && !pin_oe[0])
        else $error("mode zero match lost its request");

    a_toggle_pin: assert property (@(posedge ref_clk) disable iff (!rstn)
        clk_en && tog[2] && !set3[2] |=> pin_lvl_ff[2] != $past(pin_lvl_ff[2]))
        else $error("toggle did not invert the pin");

    a_once_period: assert property (@(posedge ref_clk) disable iff (!rstn)
        ch_mode[1] == MD_CMP2 |-> per_cnt_ff <= 2'h1)
        else $error("second compare event in one period");

    a_mode3_high: assert property (@(posedge ref_clk) disable iff (!rstn)
        s_mode3_set |=> pin_lvl_ff[4])
        else $error("mode three match did not raise the pin");

    a_mode3_low: assert property (@(posedge ref_clk) disable iff (!rstn)
        s_mode3_clr |=> !pin_lvl_ff[4])
        else $error("mode three overflow did not clear the pin");

    a_stagger_res: assert property (@(posedge ref_clk) disable iff (!rstn)
        stagger_en && tick[0] && tb_clk_sel[0] < SEL_SIX
        |-> presc_ff[STAGGER_SHIFT-1:0] == '0)
        else $error("staggered tick off the eight-cycle grid");

    a_single_evt: assert property (@(posedge ref_clk) disable iff (!rstn)
        clk_en && cmp_ev[7] && single_ev[7] |=> single_ev[7] |-> !cmp_ev[7])
        else $error("single event option produced a second event");

endmodule : capture_compare_array

/* File: tb/pin_partner.sv */
/*
 * Outside world at the sixteen channel pins.
 * Assumes the device drives a pin only while its enable is high.
 */
module pin_partner
    import cc_pkg::*;
(
    // Device side
    input  wire logic [NUM_CH-1:0] pin_out,
    input  wire logic [NUM_CH-1:0] pin_oe,
    // Outside source
    input  wire logic [NUM_CH-1:0] ext_lvl,
    // Wire level
    output logic      [NUM_CH-1:0] pin_in
);
    timeunit 1ns;
    timeprecision 1ps;

    // ========================================================
    // Driven pins read back the device, others the outside source
    assign pin_in = (pin_oe & pin_out) | (~pin_oe & ext_lvl);
endmodule : pin_partner

/* File: tb/sixteen_channel_capture_compare_test.sv */
/*
 * Self-checking bench of the capture/compare array.
 * Assumes the pin partner model and the package cc_pkg.
 */
module sixteen_channel_capture_compare_test
    import cc_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;

    // ========================================================
    // Stimulus and observed signals
    logic                ref_clk = 1'b0, rstn = 1'b0, clk_en = 1'b1;
    logic                stagger_en = 1'b0, ext_six_ovf = 1'b0;
    logic                ext_count_in = 1'b0, wr_en = 1'b0;
    logic [1:0]          tb_run = '0, tb_ovf;
    logic [1:0][2:0]     tb_clk_sel = '0;
    logic [1:0][15:0]    reload_val = '0, tb_count;
    mode_t [15:0]        ch_mode = {16{MD_OFF}};
    logic [15:0]         ch_tb_sel = '0, single_ev = '0, req_clr = '0;
    logic [15:0]         ext_lvl = '0, prev_pin = '0;
    logic [15:0]         pin_in, pin_out, pin_oe, req_flag, rd_data;
    logic [15:0][1:0]    ch_edge = '0;
    logic [7:0]          dbl_en = '0;
    logic [3:0]          wr_idx = '0, rd_idx = '0;
    logic [15:0]         wr_data = '0;
    int                  num_errors = 0, total_checks = 0, seed;
    int                  ev_cnt[16], tg_cnt[16];
    int                  exp_ev[16] = '{3,3,3,0,3,0,3,1,0,0,0,0,0,0,3,0};
    int                  exp_tg[8]  = '{0,0,3,0,5,0,6,1};

    always #12.5 ref_clk = ~ref_clk;

    capture_compare_array dut (
        .ref_clk(ref_clk), .rstn(rstn), .clk_en(clk_en),
        .tb_run(tb_run), .tb_clk_sel(tb_clk_sel), .reload_val(reload_val),
        .stagger_en(stagger_en), .ext_six_ovf(ext_six_ovf),
        .ext_count_in(ext_count_in), .tb_count(tb_count), .tb_ovf(tb_ovf),
        .ch_mode(ch_mode), .ch_tb_sel(ch_tb_sel), .ch_edge(ch_edge),
        .single_ev(single_ev), .dbl_en(dbl_en), .wr_en(wr_en),
        .wr_idx(wr_idx), .wr_data(wr_data), .rd_idx(rd_idx),
        .rd_data(rd_data), .req_clr(req_clr), .req_flag(req_flag),
        .pin_in(pin_in), .pin_out(pin_out), .pin_oe(pin_oe)
    );

    pin_partner outside (
        .pin_out(pin_out), .pin_oe(pin_oe), .ext_lvl(ext_lvl),
        .pin_in(pin_in)
    );

    // ========================================================
    // Count requests and pin edges, acknowledge every request seen
    always @(negedge ref_clk) begin
        for (int i = 0; i < 16; i++) begin
            if (req_flag[i] === 1'b1) ev_cnt[i]++;
            if (pin_out[i] !== prev_pin[i]) tg_cnt[i]++;
        end
        prev_pin = pin_out;
        req_clr  = req_flag;
    end

    // ========================================================
    // Helpers
    task automatic tick;
        @(negedge ref_clk);
        #1;
    endtask : tick

    task automatic check(input string what, input logic [15:0] seen,
                         input logic [15:0] exp);
        total_checks++;
        if (seen !== exp) begin
            num_errors++;
            $display("[ERR] %s expected %h seen %h", what, exp, seen);
        end
    endtask : check

    task automatic wr(input logic [3:0] idx, input logic [15:0] val);
        tick;
        wr_en   = 1'b1;
        wr_idx  = idx;
        wr_data = val;
        tick;
        wr_en   = 1'b0;
    endtask : wr

    task automatic rate(input int t, input logic [15:0] d, input int cyc);
        logic [15:0] c0;
        c0 = tb_count[t];
        repeat (cyc) tick;
        check("count step", tb_count[t] - c0, d);
    endtask : rate

    task automatic wait_cnt(input logic [15:0] v);
        int n;
        n = 0;
        while (tb_count[0] !== v && n < 300) begin
            tick;
            n++;
        end
        check("count reached", tb_count[0], v);
    endtask : wait_cnt

    task automatic wait_ovf(input int lim);
        int n;
        n = 0;
        tick;
        while (tb_ovf[0] !== 1'b1 && n < lim) begin
            tick;
            n++;
        end
        check("overflow seen", {15'h0000, tb_ovf[0]}, 16'h0001);
    endtask : wait_ovf

    task automatic results;
        $display("checks %0d mismatches %0d", total_checks, num_errors);
        if (num_errors == 0 && total_checks > 0) $display("TEST PASSED");
        else $display("TEST FAILED");
        $finish;
    endtask : results

    // ========================================================
    // Watchdog: the whole sequence needs some 66000 cycles
    initial begin
        repeat (90000) @(posedge ref_clk);
        num_errors++;
        results;
    end

    // ========================================================
    // Main sequence
    initial begin
        logic [15:0] c;
        logic        lvl, trig;
        int          n;
        seed = 99;
        foreach (ev_cnt[i]) begin
            ev_cnt[i] = 0;
            tg_cnt[i] = 0;
        end
        repeat (8) tick;
        rstn = 1'b1;
        check("count a", tb_count[0], CNT_RST);
        check("flags", req_flag, 16'h0000);
        check("pins", pin_out, 16'h0000);
        $display("reset test done");

        // Prescaled rates, base b stopped meanwhile
        tb_clk_sel[0] = 3'h2;
        tb_run        = 2'b01;
        rate(0, 16'h000A, 40);
        rate(1, 16'h0000, 40);
        stagger_en    = 1'b1;
        tb_clk_sel[0] = 3'h0;
        rate(0, 16'h0005, 40);
        stagger_en    = 1'b0;
        rate(0, 16'h0028, 40);
        clk_en        = 1'b0;
        rate(0, 16'h0000, 10);
        clk_en        = 1'b1;
        tb_clk_sel[1] = SEL_SIX;
        tb_run        = 2'b11;
        c = tb_count[1];
        repeat (5) begin
            ext_six_ovf = 1'b1;
            tick;
            ext_six_ovf = 1'b0;
            tick;
        end
        check("six ticks", tb_count[1] - c, 16'h0005);
        tb_clk_sel[1] = SEL_EXT;
        c = tb_count[1];
        repeat (4) begin
            ext_count_in = 1'b1;
            repeat (2) tick;
            ext_count_in = 1'b0;
            repeat (2) tick;
        end
        check("ext ticks", tb_count[1] - c, 16'h0004);
        $display("time base test done");

        // Random pin levels against every edge selection
        ch_mode[3] = MD_CAPTURE;
        rd_idx     = 4'h3;
        for (int k = 0; k < 12; k++) begin
            ch_tb_sel[3] = 1'($random(seed));
            ch_edge[3]   = 2'(k % 3 + 1);
            tick;
            n    = ev_cnt[3];
            lvl  = 1'($random(seed));
            trig = (lvl & ~ext_lvl[3] & ch_edge[3][0]) |
                   (~lvl & ext_lvl[3] & ch_edge[3][1]);
            c    = tb_count[ch_tb_sel[3]];
            ext_lvl[3] = lvl;
            repeat (3) tick;
            check("capture req", 16'(ev_cnt[3] - n), 16'(trig));
            if (trig) check("capture val", rd_data, c);
        end
        ch_mode[3] = MD_OFF;
        $display("capture test done");

        // Reach the short reload period, then pause base a
        reload_val[0] = 16'hFFF0;
        wait_ovf(70000);
        check("reload", tb_count[0], 16'hFFF0);
        tb_run[0]   = 1'b0;
        ch_mode[0]  = MD_CMP0;
        ch_mode[1]  = MD_CMP2;
        ch_mode[2]  = MD_CMP1;
        ch_mode[4]  = MD_CMP3;
        ch_mode[6]  = MD_CMP1;
        ch_mode[14] = MD_CMP1;
        ch_mode[7]  = MD_CMP1;
        ch_tb_sel   = '0;
        dbl_en[6]   = 1'b1;
        single_ev[7] = 1'b1;
        wr(4'h0, 16'hFFF2);
        wr(4'h1, 16'hFFF2);
        wr(4'h2, 16'hFFF6);
        wr(4'h4, 16'hFFF6);
        wr(4'h6, 16'hFFF3);
        wr(4'hE, 16'hFFFB);
        wr(4'h7, 16'hFFF5);
        wr(4'h8, 16'hFFF5);
        tick;
        foreach (ev_cnt[i]) begin
            ev_cnt[i] = 0;
            tg_cnt[i] = 0;
        end
        check("drive enables", pin_oe, 16'h00D4);
        tb_run[0] = 1'b1;
        repeat (3) begin
            wait_cnt(16'hFFF3);
            check("mode3 low", {15'h0000, pin_out[4]}, 16'h0000);
            wait_cnt(16'hFFF9);
            check("mode3 high", {15'h0000, pin_out[4]}, 16'h0001);
            wait_ovf(20);
        end
        foreach (exp_ev[i]) check("requests", 16'(ev_cnt[i]), 16'(exp_ev[i]));
        foreach (exp_tg[i]) check("pin edges", 16'(tg_cnt[i]), 16'(exp_tg[i]));
        wait_cnt(16'hFFF4);
        wr(4'h0, 16'hFFFA);
        wr(4'h1, 16'hFFFA);
        wait_ovf(20);
        check("mode0 repeat", 16'(ev_cnt[0]), 16'h0005);
        check("mode2 once", 16'(ev_cnt[1]), 16'h0004);
        $display("compare test done");

        // Second reset in mid-run
        rstn = 1'b0;
        tick;
        check("count reset", tb_count[0], CNT_RST);
        check("pin reset", pin_out, 16'h0000);
        rstn = 1'b1;
        repeat (2) tick;
        check("count restart", tb_count[0], 16'h0002);
        $display("mid-run reset test done");
        results;
    end
endmodule : sixteen_channel_capture_compare_test
